//--- hw/csba_bcd_unit.sv
// packed-bcd correction of the accumulator
`timescale 1ns/1ps
module csba_bcd_unit
	import csba_pkg::*;
(
	// operand
	input wire logic [7:0] i_acc,
	input wire csba_flags_t i_flags,
	// result
	output csba_bcd_t o_result
);

	logic lo_fix;
	logic hi_fix;
	logic [4:0] lo_sum;
	logic [4:0] hi_sum;
	logic [4:0] hi_in;

	// ---------------------------------------------------------------
	// nibble corrections
	// ---------------------------------------------------------------
	always_comb
	begin
		lo_fix = (i_acc[3:0] > CSBA_BCD_LIMIT) || i_flags.nibble_half_flag;
		lo_sum = {1'b0, i_acc[3:0]} + (lo_fix ? CSBA_BCD_FIX : CSBA_BCD_NONE);
		hi_in = {1'b0, i_acc[7:4]} + {4'h0, lo_sum[4]};
		hi_fix = (hi_in > {1'b0, CSBA_BCD_LIMIT}) || i_flags.carry;
		hi_sum = hi_in + (hi_fix ? CSBA_BCD_FIX : CSBA_BCD_NONE);
		o_result.value = {hi_sum[3:0], lo_sum[3:0]};
		o_result.carry = i_flags.carry | hi_sum[4];
	end

endmodule : csba_bcd_unit

//--- hw/csba_exec.sv
// execution of compare-and-skip and decimal adjust instructions
`timescale 1ns/1ps
// Overview of operation
// - 0110 001a: skip when register equals accumulator
// - 0110 010a: skip-if-greater decode
// - 0110 000a: skip-if-less decode
// - greater: discard next instruction, run no-op
// - less: discard next instruction, run no-op
// - unsigned subtract compare, no flag or operand change
// - one, two or three cycles of four phases
// - bank bit 0 quick region, 1 bank pointer
// - 8-bit register address plus one bank bit
// - decimal adjust 0x0007, one word, one cycle
// - low nibble plus six if above nine or half-flag
// - high nibble plus six if above nine or carry
module csba_exec
	import csba_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// instruction from fetch, taken in its decode phase
	input wire logic i_instr_valid,
	input wire logic [15:0] i_instr,
	input wire logic i_next_two_word,
	// operands
	input wire logic [3:0] i_bank_pointer,
	input wire logic [7:0] i_file_data,
	input wire logic [7:0] i_accumulator_alias,
	input wire csba_flags_t i_flags,
	// data memory read
	output logic o_file_rd,
	output logic [11:0] o_file_addr,
	// accumulator and flag write back
	output logic o_acc_we,
	output logic [7:0] o_acc_wdata,
	output logic o_carry_we,
	output csba_flags_t o_flags,
	// sequencing
	output logic o_busy,
	output logic o_done,
	output logic o_skip,
	output logic o_flush,
	output logic o_flush_word
);

	csba_state_t state;
	csba_state_t next_state;
	logic [1:0] phase;
	logic [1:0] next_phase;
	csba_op_t op;
	csba_op_t next_op;
	csba_op_t dec_op;
	logic [1:0] flush_left;
	logic [1:0] next_flush_left;
	logic two_word;
	logic next_two_word;
	logic next_file_rd;
	logic [11:0] next_file_addr;
	logic next_acc_we;
	logic [7:0] next_acc_wdata;
	logic next_carry_we;
	csba_flags_t next_flags;
	logic next_busy;
	logic next_done;
	logic next_skip;
	logic next_flush;
	logic next_flush_word;
	logic [8:0] diff;
	logic take_skip;
	csba_bcd_t bcd;

	// ---------------------------------------------------------------
	// decimal correction unit
	// ---------------------------------------------------------------
	csba_bcd_unit u_bcd
	(
		.i_acc(i_accumulator_alias),
		.i_flags(i_flags),
		.o_result(bcd)
	);

	// ---------------------------------------------------------------
	// opcode decode
	// ---------------------------------------------------------------
	always_comb
	begin
		if (i_instr == CSBA_OPC_BCD)
		begin
			dec_op = CSBA_OP_BCD;
		end
		else if (i_instr[CSBA_OPC_MSB:CSBA_OPC_LSB] == CSBA_OPC_EQUAL)
		begin
			dec_op = CSBA_OP_EQUAL;
		end
		else if (i_instr[CSBA_OPC_MSB:CSBA_OPC_LSB] == CSBA_OPC_GREATER)
		begin
			dec_op = CSBA_OP_GREATER;
		end
		else if (i_instr[CSBA_OPC_MSB:CSBA_OPC_LSB] == CSBA_OPC_LESS)
		begin
			dec_op = CSBA_OP_LESS;
		end
		else
		begin
			dec_op = CSBA_OP_NONE;
		end
	end

	// ---------------------------------------------------------------
	// unsigned compare
	// ---------------------------------------------------------------
	always_comb
	begin
		diff = {1'b0, i_file_data} - {1'b0, i_accumulator_alias};
		case (op)
			CSBA_OP_EQUAL: take_skip = (diff == 9'h000);
			CSBA_OP_GREATER: take_skip = !diff[8] && (diff != 9'h000);
			CSBA_OP_LESS: take_skip = diff[8];
			default: take_skip = 1'b0;
		endcase
	end

	// ---------------------------------------------------------------
	// sequencer next state
	// ---------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_phase = phase;
		next_op = op;
		next_flush_left = flush_left;
		next_two_word = two_word;
		next_file_rd = 1'b0;
		next_file_addr = o_file_addr;
		next_acc_we = 1'b0;
		next_acc_wdata = o_acc_wdata;
		next_carry_we = 1'b0;
		next_flags = o_flags;
		next_done = 1'b0;
		next_skip = o_skip;
		next_flush_word = 1'b0;
		case (state)
			CSBA_ST_IDLE:
			begin
				next_skip = 1'b0;
				if (i_instr_valid && (dec_op != CSBA_OP_NONE))
				begin
					next_state = CSBA_ST_EXEC;
					next_phase = CSBA_PH_Q2;
					next_op = dec_op;
					if (dec_op != CSBA_OP_BCD)
					begin
						next_file_rd = 1'b1;
						if (i_instr[CSBA_BANK_BIT] == CSBA_BANK_USE_QUICK)
						begin
							next_file_addr = {CSBA_QUICK_BANK, i_instr[7:0]};
						end
						else
						begin
							next_file_addr = {i_bank_pointer, i_instr[7:0]};
						end
					end
				end
			end
			CSBA_ST_EXEC:
			begin
				next_phase = phase + CSBA_PH_STEP;
				if (phase == CSBA_PH_Q3)
				begin
					next_done = 1'b1;
					next_two_word = i_next_two_word;
					if (op == CSBA_OP_BCD)
					begin
						next_acc_we = 1'b1;
						next_acc_wdata = bcd.value;
						next_carry_we = 1'b1;
						next_flags.carry = bcd.carry;
						next_flags.nibble_half_flag = i_flags.nibble_half_flag;
					end
					else
					begin
						next_skip = take_skip;
					end
				end
				else if (phase == CSBA_PH_Q4)
				begin
					next_op = CSBA_OP_NONE;
					if (o_skip)
					begin
						next_state = CSBA_ST_FLUSH;
						next_phase = CSBA_PH_Q1;
						next_flush_word = 1'b1;
						next_flush_left = two_word ? CSBA_FLUSH_TWO : CSBA_FLUSH_ONE;
					end
					else
					begin
						next_state = CSBA_ST_IDLE;
						next_phase = CSBA_PH_Q1;
					end
				end
			end
			CSBA_ST_FLUSH:
			begin
				next_phase = phase + CSBA_PH_STEP;
				if (phase == CSBA_PH_Q4)
				begin
					if (flush_left == CSBA_FLUSH_ONE)
					begin
						next_state = CSBA_ST_IDLE;
						next_skip = 1'b0;
					end
					else
					begin
						next_flush_word = 1'b1;
						next_flush_left = flush_left - CSBA_FLUSH_ONE;
					end
				end
			end
			default:
			begin
				next_state = CSBA_ST_IDLE;
				next_phase = CSBA_PH_Q1;
			end
		endcase
		next_busy = (next_state != CSBA_ST_IDLE);
		next_flush = (next_state == CSBA_ST_FLUSH);
	end

	// ---------------------------------------------------------------
	// sequencer registers
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state <= CSBA_ST_IDLE;
			phase <= CSBA_PH_Q1;
			op <= CSBA_OP_NONE;
			flush_left <= CSBA_FLUSH_ONE;
			two_word <= 1'b0;
			o_file_rd <= 1'b0;
			o_file_addr <= 12'h000;
			o_acc_we <= 1'b0;
			o_acc_wdata <= 8'h00;
			o_carry_we <= 1'b0;
			o_flags <= '0;
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_skip <= 1'b0;
			o_flush <= 1'b0;
			o_flush_word <= 1'b0;
		end
		else
		begin
			state <= next_state;
			phase <= next_phase;
			op <= next_op;
			flush_left <= next_flush_left;
			two_word <= next_two_word;
			o_file_rd <= next_file_rd;
			o_file_addr <= next_file_addr;
			o_acc_we <= next_acc_we;
			o_acc_wdata <= next_acc_wdata;
			o_carry_we <= next_carry_we;
			o_flags <= next_flags;
			o_busy <= next_busy;
			o_done <= next_done;
			o_skip <= next_skip;
			o_flush <= next_flush;
			o_flush_word <= next_flush_word;
		end
	end

endmodule : csba_exec

//--- hw/csba_pkg.sv
// shared constants and types for the compare-skip and decimal adjust unit
package csba_pkg;

	// ---------------------------------------------------------------
	// opcode patterns
	// ---------------------------------------------------------------
	localparam logic [6:0] CSBA_OPC_LESS = 7'h30;
	localparam logic [6:0] CSBA_OPC_EQUAL = 7'h31;
	localparam logic [6:0] CSBA_OPC_GREATER = 7'h32;
	localparam logic [15:0] CSBA_OPC_BCD = 16'h0007;
	localparam int unsigned CSBA_OPC_MSB = 15;
	localparam int unsigned CSBA_OPC_LSB = 9;
	localparam int unsigned CSBA_BANK_BIT = 8;

	// ---------------------------------------------------------------
	// data memory addressing
	// ---------------------------------------------------------------
	localparam logic [3:0] CSBA_QUICK_BANK = 4'h0;
	localparam logic CSBA_BANK_USE_QUICK = 1'b0;

	// ---------------------------------------------------------------
	// quarter phases and timing
	// ---------------------------------------------------------------
	localparam logic [1:0] CSBA_PH_Q1 = 2'h0;
	localparam logic [1:0] CSBA_PH_Q2 = 2'h1;
	localparam logic [1:0] CSBA_PH_Q3 = 2'h2;
	localparam logic [1:0] CSBA_PH_Q4 = 2'h3;
	localparam logic [1:0] CSBA_PH_STEP = 2'h1;
	localparam logic [1:0] CSBA_FLUSH_ONE = 2'h1;
	localparam logic [1:0] CSBA_FLUSH_TWO = 2'h2;
	localparam real CSBA_CLK_PERIOD_NS = 4.0;

	// ---------------------------------------------------------------
	// decimal correction
	// ---------------------------------------------------------------
	localparam logic [3:0] CSBA_BCD_LIMIT = 4'h9;
	localparam logic [4:0] CSBA_BCD_FIX = 5'h06;
	localparam logic [4:0] CSBA_BCD_NONE = 5'h00;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [1:0]
	{
		CSBA_ST_IDLE = 2'b00,
		CSBA_ST_EXEC = 2'b01,
		CSBA_ST_FLUSH = 2'b10
	} csba_state_t;

	typedef enum logic [2:0]
	{
		CSBA_OP_NONE = 3'b000,
		CSBA_OP_EQUAL = 3'b001,
		CSBA_OP_GREATER = 3'b010,
		CSBA_OP_LESS = 3'b011,
		CSBA_OP_BCD = 3'b100
	} csba_op_t;

	typedef struct packed
	{
		logic carry;
		logic nibble_half_flag;
	} csba_flags_t;

	typedef struct packed
	{
		logic [7:0] value;
		logic carry;
	} csba_bcd_t;

endpackage : csba_pkg

//--- sim/csba_exec_props.sv
// port assertions for the compare-skip and decimal adjust unit
`timescale 1ns/1ps
module csba_exec_chk
	import csba_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// inputs
	input wire logic i_instr_valid,
	input wire logic [15:0] i_instr,
	input wire logic i_next_two_word,
	input wire logic [3:0] i_bank_pointer,
	input wire logic [7:0] i_file_data,
	input wire logic [7:0] i_accumulator_alias,
	input wire csba_flags_t i_flags,
	// outputs
	input wire logic o_file_rd,
	input wire logic [11:0] o_file_addr,
	input wire logic o_acc_we,
	input wire logic [7:0] o_acc_wdata,
	input wire logic o_carry_we,
	input wire csba_flags_t o_flags,
	input wire logic o_busy,
	input wire logic o_done,
	input wire logic o_skip,
	input wire logic o_flush,
	input wire logic o_flush_word
);
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	logic take, is_cmp, is_bcd;
	logic [6:0] op_q, next_op_q;
	assign is_cmp = i_instr[15:9] inside {CSBA_OPC_LESS, CSBA_OPC_EQUAL, CSBA_OPC_GREATER};
	assign is_bcd = i_instr == CSBA_OPC_BCD;
	assign take = !o_busy && i_instr_valid;
	always_comb next_op_q = (take && is_cmp) ? i_instr[15:9] : op_q;
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			op_q <= 7'h00;
		else
			op_q <= next_op_q;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	rd_addr_a: assert property (take && is_cmp |=> o_file_rd && o_file_addr ==
		{$past(i_instr[8]) ? $past(i_bank_pointer) : CSBA_QUICK_BANK, $past(i_instr[7:0])})
		else $error("compare read address wrong");
	cmp_done_a: assert property (take && is_cmp |-> ##3 o_done && !o_acc_we && !o_carry_we)
		else $error("compare completion wrong");
	bcd_write_a: assert property (take && is_bcd |=> !o_file_rd ##2 o_done && o_acc_we)
		else $error("adjust write wrong");
	refuse_a: assert property (take && !is_cmp && !is_bcd |=> !o_busy)
		else $error("bad word accepted");
	skip_rule_a: assert property (o_done && !o_acc_we |-> o_skip == (op_q == CSBA_OPC_EQUAL ?
		$past(i_file_data) == $past(i_accumulator_alias) : op_q == CSBA_OPC_GREATER ?
		$past(i_file_data) > $past(i_accumulator_alias) :
		$past(i_file_data) < $past(i_accumulator_alias)))
		else $error("skip decision wrong");
	skip_flush_a: assert property (o_done && o_skip |=> o_flush && o_flush_word)
		else $error("skip did not flush");
	flush_len_a: assert property ($rose(o_flush) |-> o_flush[*4] ##1
		(!o_flush or (o_flush_word ##0 o_flush[*4] ##1 !o_flush)))
		else $error("flush length wrong");
	noskip_end_a: assert property (o_done && !o_skip |=> !o_busy && !o_flush)
		else $error("no-skip instruction too long");
	half_keep_a: assert property (o_carry_we |-> o_flags.nibble_half_flag ==
		$past(i_flags.nibble_half_flag) && (o_flags.carry || !$past(i_flags.carry)))
		else $error("adjust flags wrong");
	cover property (o_flush_word ##4 o_flush_word);
	cover property (o_acc_we && o_flags.carry);
	cover property (take && !is_cmp && !is_bcd);
endmodule : csba_exec_chk

bind csba_exec csba_exec_chk i_chk (.*);

//--- sim/tb.sv
// self-checking bench for the compare-skip and decimal adjust unit
`timescale 1ns/1ps
module tb;
	import csba_pkg::*;
	logic i_clk = 0, i_rst_n = 0, i_instr_valid = 0, i_next_two_word = 0;
	logic [15:0] i_instr = 16'h0000;
	logic [3:0] i_bank_pointer = 4'h0;
	logic [7:0] i_file_data = 8'h00, i_accumulator_alias = 8'h00;
	csba_flags_t i_flags = 2'h0;
	logic o_file_rd, o_acc_we, o_carry_we, o_busy, o_done, o_skip, o_flush, o_flush_word;
	logic [11:0] o_file_addr;
	logic [7:0] o_acc_wdata;
	csba_flags_t o_flags;
	int bad_count = 0, num_checks = 0;
	logic [15:0] n, fw, ad;
	logic rd, sk, we;
	logic [7:0] wd;
	csba_flags_t cf;
	csba_exec i_csba_exec (.*);
	initial forever #2 i_clk = ~i_clk;
	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic end_of_test;
		if (bad_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic run(input logic [15:0] ins, input logic [7:0] f, input logic [7:0] w,
		input csba_flags_t fl, input logic two);
		i_instr_valid = 1;
		i_instr = ins;
		@(posedge i_clk);
		#1;
		i_instr_valid = 0;
		i_file_data = f;
		i_accumulator_alias = w;
		i_flags = fl;
		i_next_two_word = two;
		rd = o_file_rd;
		ad = {4'h0, o_file_addr};
		n = 16'h0000;
		fw = 16'h0000;
		sk = 1'bx;
		we = 1'bx;
		while (o_busy === 1'b1 && n < 16'h0010)
		begin
			if (o_done === 1'b1)
			begin
				sk = o_skip;
				we = o_acc_we | o_carry_we;
				wd = o_acc_wdata;
				cf = o_flags;
			end
			fw = fw + {15'h0000, o_flush_word};
			n = n + 16'h0001;
			@(posedge i_clk);
			#1;
		end
	endtask : run
	task automatic cmpc(input logic [6:0] op, input logic a, input logic [7:0] r,
		input logic [7:0] f, input logic [7:0] w, input logic two, input logic xs);
		logic [15:0] k;
		k = xs ? (two ? 16'h0002 : 16'h0001) : 16'h0000;
		run({op, a, r}, f, w, 2'h3, two);
		check(rd, 1'b1);
		check(ad, {4'h0, a ? i_bank_pointer : CSBA_QUICK_BANK, r});
		check(sk, xs);
		check(n, 16'h0003 + 16'h0004 * k);
		check(fw, k);
		check(we, 1'b0);
	endtask : cmpc
	function automatic logic [8:0] bcd_exp(input logic [7:0] a, input csba_flags_t fl);
		logic [4:0] lo, hi;
		lo = {1'b0, a[3:0]} + ((a[3:0] > 4'h9 || fl.nibble_half_flag) ? 5'h06 : 5'h00);
		hi = {1'b0, a[7:4]} + {4'h0, lo[4]};
		hi = hi + ((hi > 5'h09 || fl.carry) ? 5'h06 : 5'h00);
		return {fl.carry | hi[4], hi[3:0], lo[3:0]};
	endfunction : bcd_exp
	task automatic bcd_case(input logic [7:0] a, input csba_flags_t fl);
		logic [8:0] x;
		x = bcd_exp(a, fl);
		run(CSBA_OPC_BCD, 8'hEE, a, fl, 1'b1);
		check(n, 16'h0003);
		check(rd, 1'b0);
		check(we, 1'b1);
		check(wd, x[7:0]);
		check(cf, {x[8], fl.nibble_half_flag});
	endtask : bcd_case
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_equal;
		i_bank_pointer = 4'h5;
		cmpc(CSBA_OPC_EQUAL, 1, 8'hFF, 8'h3C, 8'h3C, 0, 1);
		cmpc(CSBA_OPC_EQUAL, 0, 8'h00, 8'h3C, 8'h3D, 0, 0);
		cmpc(CSBA_OPC_EQUAL, 0, 8'h80, 8'h00, 8'h00, 1, 1);
	endtask : t_equal
	task automatic t_greater;
		i_bank_pointer = 4'hA;
		cmpc(CSBA_OPC_GREATER, 1, 8'h12, 8'h81, 8'h80, 1, 1);
		cmpc(CSBA_OPC_GREATER, 1, 8'h12, 8'h80, 8'h80, 1, 0);
		cmpc(CSBA_OPC_GREATER, 0, 8'h34, 8'hFF, 8'h00, 0, 1);
	endtask : t_greater
	task automatic t_less;
		cmpc(CSBA_OPC_LESS, 1, 8'h56, 8'h7F, 8'h80, 0, 1);
		cmpc(CSBA_OPC_LESS, 0, 8'h56, 8'h80, 8'h80, 1, 0);
		cmpc(CSBA_OPC_LESS, 1, 8'h01, 8'h00, 8'hFF, 1, 1);
	endtask : t_less
	task automatic t_bcd;
		bcd_case(8'hA5, 2'h0);
		check(wd, 8'h05);
		check(cf, 2'h2);
		bcd_case(8'h13, 2'h1);
		bcd_case(8'h45, 2'h0);
		bcd_case(8'h00, 2'h2);
		bcd_case(8'h9A, 2'h0);
		check(wd, 8'h00);
		check(cf, 2'h2);
		bcd_case(8'hFF, 2'h3);
	endtask : t_bcd
	task automatic t_refuse;
		i_instr_valid = 1;
		i_instr = 16'h6800;
		@(posedge i_clk);
		#1;
		check(o_busy, 1'b0);
		i_instr = 16'h0006;
		@(posedge i_clk);
		#1;
		check(o_busy, 1'b0);
		i_instr_valid = 0;
	endtask : t_refuse
	initial
	begin
		repeat (20) @(posedge i_clk);
		#1;
		i_rst_n = 1;
		t_equal();
		t_greater();
		t_less();
		t_bcd();
		t_refuse();
		end_of_test();
	end
	initial
	begin
		#20000;
		bad_count++;
		end_of_test();
	end
endmodule : tb
